// File: hw/thermal_trip_defs.svh
`ifndef THERMAL_TRIP_DEFS_SVH
`define THERMAL_TRIP_DEFS_SVH

// Clock rate in kHz (40 MHz)
`define TT_CLK_KHZ          40000
// Trip margin above the maximum case temperature, in degrees C
`define TT_TRIP_MARGIN_C    20
// Longest time from supply_valid_in rising to output drive, in microseconds
`define TT_ENABLE_US        10
// Drive-enable delay in cycles, rounded down from the longest time
`define TT_ENABLE_CYCLES    ((`TT_ENABLE_US * `TT_CLK_KHZ) / 1000)
// Settle cycles spent before driving; well inside the 10 us bound
`define TT_SETTLE_CYCLES    16
// Synchroniser depth
`define TT_SYNC_STAGES      2

`endif

// File: hw/thermal_trip_pkg.sv
package thermal_trip_pkg;

    // Supply indications arriving on pins
    typedef struct packed {
        logic supply_valid_in;
        logic bus_supply_valid;
        logic core_supply_valid;
    } supply_t;

    typedef enum logic [1:0] {
        ST_OFF     = 2'b00,
        ST_SETTLE  = 2'b01,
        ST_ARMED   = 2'b10,
        ST_TRIPPED = 2'b11
    } trip_state_t;

    function automatic logic supplies_good(input supply_t s);
        return s.supply_valid_in & s.bus_supply_valid & s.core_supply_valid;
    endfunction

endpackage

// File: hw/trip_sync.sv
`timescale 1ns/1ps
`default_nettype none

module trip_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire  logic             mclk,
    input  wire  logic             resetn,
    input  wire  logic             clk_en,
    // Data
    input  wire  logic [WIDTH-1:0] async_in,
    output var   logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (clk_en) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule // trip_sync

`default_nettype wire

// File: hw/thermal_trip_latch.sv
`include "thermal_trip_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module thermal_trip_latch
    import thermal_trip_pkg::*;
#(
    parameter int ENABLE_CYCLES = `TT_ENABLE_CYCLES,
    parameter int SETTLE_CYCLES = `TT_SETTLE_CYCLES
) (
    // Clock, reset, enable
    input  wire  logic                      mclk,
    input  wire  logic                      resetn,
    input  wire  logic                      clk_en,
    // Pins and comparator (asynchronous)
    input  wire  thermal_trip_pkg::supply_t supply_pins,
    input  wire  logic                      over_temp,
    // Outputs
    output var   logic                      thermal_shutdown_out,
    output var   logic                      drive_enable,
    output var   logic                      core_clock_stop
);
    import thermal_trip_pkg::*;

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // The settle counter is 8 bits wide, and it must expire inside the
    // enable bound, otherwise driving could start too late.
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255) begin : g_bad_settle
        $error("SETTLE_CYCLES must lie in 1..255");
    end
    if (SETTLE_CYCLES > ENABLE_CYCLES) begin : g_slow_settle
        $error("SETTLE_CYCLES must not exceed ENABLE_CYCLES");
    end

    // ----------------------------------------------------------------
    // Output decode
    // ----------------------------------------------------------------
    // Both decodes are gated by the synchronised supply verdict, so a
    // supply loss drops the outputs on the same edge the state leaves.
    function automatic logic shutdown_level(input trip_state_t st, input logic g);
        return g && (st == ST_TRIPPED);
    endfunction

    function automatic logic drive_level(input trip_state_t st, input logic g);
        return g && (st == ST_ARMED || st == ST_TRIPPED);
    endfunction

    // ----------------------------------------------------------------
    // Synchronisers
    // ----------------------------------------------------------------
    logic [3:0]  sync_bits;
    supply_t     supply_s;
    logic        hot_s;

    trip_sync #(
        .WIDTH (4)
    ) u_sync (
        .mclk     (mclk),
        .resetn   (resetn),
        .clk_en   (clk_en),
        .async_in ({supply_pins, over_temp}),
        .sync_out (sync_bits)
    );

    assign supply_s = supply_t'(sync_bits[3:1]);
    assign hot_s    = sync_bits[0];

    // ----------------------------------------------------------------
    // Drive-enable sequencing and latch
    // ----------------------------------------------------------------
    // The comparator threshold itself (20 C margin) lives in the
    // analogue sensor; over_temp is its digital verdict.
    trip_state_t state;
    trip_state_t next_state;
    logic [7:0]  settle;
    logic        good;
    logic        settle_done;

    assign good        = supplies_good(supply_s);
    assign settle_done = (settle == 8'(SETTLE_CYCLES - 1));

    // Next-state decode
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (good) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (!good) begin
                    next_state = ST_OFF;
                end else if (settle_done) begin
                    next_state = ST_ARMED;
                end
            end
            ST_ARMED: begin
                // over_temp is ignored until here, so a hot power-up
                // cannot latch before the output may be driven
                if (!good) begin
                    next_state = ST_OFF;
                end else if (hot_s) begin
                    next_state = ST_TRIPPED;
                end
            end
            ST_TRIPPED: begin
                // Only loss of a supply indication clears; cooling does not
                if (!good) begin
                    next_state = ST_OFF;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state <= ST_OFF;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    // Settle counter: cleared outside SETTLE so that every power-up,
    // including a re-power while hot, waits the full settle time
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            settle <= 8'h00;
        end else if (clk_en) begin
            if (state != ST_SETTLE) begin
                settle <= 8'h00;
            end else if (!settle_done) begin
                settle <= settle + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Outputs follow state one cycle later; the total stays far below
    // the 10 us bound, so re-trip after power returns is timely.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            thermal_shutdown_out <= 1'b0;
            drive_enable         <= 1'b0;
            core_clock_stop      <= 1'b0;
        end else if (clk_en) begin
            drive_enable         <= drive_level(state, good);
            thermal_shutdown_out <= shutdown_level(state, good);
            // Clock stop shares the shutdown decode so the two never part
            core_clock_stop      <= shutdown_level(state, good);
        end
    end

endmodule // thermal_trip_latch

`default_nettype wire

// File: dv/plat_power.sv
`timescale 1ns/1ps
`default_nettype none
module plat_power (
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic shutdown,
    input  wire logic restore,
    output var  logic core_ok
);
    // Core rail is dropped on the shutdown level, held off until restored
    always_ff @(posedge mclk) begin
        if (!resetn || restore) core_ok <= 1'b1;
        else if (shutdown) core_ok <= 1'b0;
    end
endmodule // plat_power
`default_nettype wire

// File: dv/thermal_trip_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_trip_monitor
    import thermal_trip_pkg::*;
#(
    parameter int SETTLE_CYCLES = 16
) (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    input  wire logic                      clk_en,
    // Pins and outputs
    input  wire thermal_trip_pkg::supply_t supply_pins,
    input  wire logic                      over_temp,
    input  wire logic                      thermal_shutdown_out,
    input  wire logic                      drive_enable,
    input  wire logic                      core_clock_stop
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn || !clk_en);
    // Consecutive samples with all supply pins good; counts only with clk_en, clears on any pin loss regardless
    logic [15:0] good_cnt;
    always_ff @(posedge mclk) begin
        if (!resetn || !(&supply_pins)) good_cnt <= 16'h0000;
        else if (clk_en && good_cnt != 16'hffff) good_cnt <= good_cnt + 16'h0001;
    end
    sequence good_run; (&supply_pins)[*4]; endsequence
    sequence hot_run; (over_temp && drive_enable && &supply_pins)[*5]; endsequence
    clock_stop_a: assert property (core_clock_stop == thermal_shutdown_out)
        else $error("clock stop differs from shutdown");
    trip_set_a: assert property (hot_run |=> thermal_shutdown_out)
        else $error("trip not latched");
    no_early_a: assert property ($rose(thermal_shutdown_out) |-> $past(drive_enable))
        else $error("trip latched before drive enable");
    drive_on_a: assert property (&supply_pins && good_cnt >= 16'(SETTLE_CYCLES + 5) |-> drive_enable)
        else $error("drive not enabled in time");
    drive_off_a: assert property ((!(&supply_pins))[*4] |-> !drive_enable && !thermal_shutdown_out)
        else $error("drive kept after supply loss");
    latch_hold_a: assert property (good_run ##0 thermal_shutdown_out |=> thermal_shutdown_out)
        else $error("latch dropped with supplies good");
    retrip_a: assert property ($rose(drive_enable) ##0 hot_run |=> thermal_shutdown_out)
        else $error("no retrip after power return");
endmodule // thermal_trip_monitor
bind thermal_trip_latch thermal_trip_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES))
    u_thermal_trip_monitor (.mclk(mclk), .resetn(resetn),
    .clk_en(clk_en), .supply_pins(supply_pins), .over_temp(over_temp),
    .thermal_shutdown_out(thermal_shutdown_out), .drive_enable(drive_enable),
    .core_clock_stop(core_clock_stop));
`default_nettype wire

// File: dv/thermal_trip_latch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module thermal_trip_latch_tb_top;
    import thermal_trip_pkg::*;
    logic mclk = 0, resetn = 0, svi = 0, bus = 1, hot = 0, restore = 0, en = 1;
    logic shut, de, cs, core;
    supply_t pins;
    int n_errors = 0, n_compared = 0, cyc = 0;
    assign pins = {svi, bus, core};
    initial forever #12.5 mclk = ~mclk;
    thermal_trip_latch #(.SETTLE_CYCLES(2)) u_thermal_trip_latch (.mclk(mclk), .resetn(resetn),
        .clk_en(en), .supply_pins(pins), .over_temp(hot), .thermal_shutdown_out(shut),
        .drive_enable(de), .core_clock_stop(cs));
    plat_power u_plat_power (.mclk(mclk), .resetn(resetn), .shutdown(shut), .restore(restore),
        .core_ok(core));
    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic s, input logic e);
        n_compared++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %0t unexpected output level", $time);
        end
    endtask
    task automatic wt(ref logic s, input logic v);
        for (int i = 0; i < 40 && s !== v; i++) @(posedge mclk);
        chk(s, v);
    endtask
    task automatic t_trip;
        @(posedge mclk) svi <= 1;
        wt(de, 1);
        chk(shut, 0);
        @(posedge mclk) hot <= 1;
        wt(shut, 1);
        chk(cs, 1);
        wt(shut, 0);
    endtask
    task automatic t_retrip;
        @(posedge mclk) restore <= 1;
        wt(de, 1);
        wt(shut, 1);
        @(posedge mclk) hot <= 0;
        repeat (6) @(posedge mclk);
        chk(shut, 1);
        bus <= 0;
        wt(shut, 0);
        chk(de, 0);
    endtask
    task automatic t_svi_drop;
        @(posedge mclk) bus <= 1;
        wt(de, 1);
        // Freeze while supply_valid_in drops: nothing may move until enabled
        @(posedge mclk);
        en  <= 0;
        svi <= 0;
        repeat (6) @(posedge mclk);
        chk(de, 1);
        en <= 1;
        wt(de, 0);
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 1000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        resetn <= 1;
        t_trip();
        t_retrip();
        t_svi_drop();
        conclude();
    end
endmodule // thermal_trip_latch_tb_top
`default_nettype wire
